// File: shared/uct_map.vh
`ifndef UCT_MAP_VH
`define UCT_MAP_VH

// Register byte offsets, one aligned word each
`define UCT_A_RELOAD_LO   8'h00
`define UCT_A_RELOAD_HI   8'h04
`define UCT_A_COUNT_LO    8'h08
`define UCT_A_COUNT_HI    8'h0c
`define UCT_A_AUX_CTRL    8'h10
`define UCT_A_INT_STATUS  8'h14
`define UCT_A_INT_MASK    8'h18
`define UCT_A_CMD_A       8'h1c
`define UCT_A_CMD_B       8'h20
`define UCT_A_START       8'h24
`define UCT_A_STOP        8'h28
`define UCT_A_CLK_SEL     8'h2c
`define UCT_A_W           8

// aux_control fields
`define UCT_AUX_MODE_BIT  6
`define UCT_AUX_SRC_HI    5
`define UCT_AUX_SRC_LO    4
`define UCT_AUX_PIN_BIT   3
`define UCT_AUX_MASK      8'h78

// Clock source codes in aux_control[5:4]
`define UCT_SRC_EXT       2'b00
`define UCT_SRC_EXT16     2'b01
`define UCT_SRC_X1        2'b10
`define UCT_SRC_X116      2'b11

// interrupt_status / interrupt_mask
`define UCT_ISR_READY_BIT 3
`define UCT_ISR_W         8

// Channel commands, upper nibble
`define UCT_CMD_TO_ON     4'ha
`define UCT_CMD_TO_OFF    4'hc

// Counter constants
`define UCT_CNT_W         16
`define UCT_CNT_ROLL      16'hff55
`define UCT_CNT_ONE       16'h0001
`define UCT_CNT_ZERO      16'h0000
`define UCT_PRE_W         4
`define UCT_PRE_LAST      4'hf
`define UCT_CSEL_W        4

// AHB encodings
`define UCT_HTRANS_NSEQ_BIT 1
`define UCT_HRESP_OKAY    1'b0
`define UCT_DATA_W        32
`define UCT_ZERO32        32'h0000_0000

`endif

// File: verilog/uct_sync.v
`timescale 1ns/100ps
module uct_sync #(
  parameter WIDTH = 1
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             ce,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else if (ce) begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

// File: verilog/uct_tick.v
`timescale 1ns/100ps
`include "uct_map.vh"
module uct_tick (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       ce,
  input  wire [1:0] src_sel,
  input  wire       ext_level,
  input  wire       x1_tick,
  output reg        tick
);

  reg                   ext_prev;
  reg [`UCT_PRE_W-1:0]  prescale;
  wire                  ext_rise;
  wire                  base;
  wire                  div16;

  assign ext_rise = ext_level & ~ext_prev;
  assign base     = src_sel[1] ? x1_tick : ext_rise;
  // Odd codes divide the chosen source by sixteen
  assign div16    = src_sel[0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev <= 1'b0;
      prescale <= {`UCT_PRE_W{1'b0}};
      tick     <= 1'b0;
    end else if (ce) begin
      ext_prev <= ext_level;
      if (base) begin
        prescale <= prescale + 4'h1;
      end
      tick <= base & (~div16 | (prescale == `UCT_PRE_LAST));
    end
  end

endmodule

// File: verilog/uct_counter_timer.v
`timescale 1ns/100ps
`include "uct_map.vh"
module uct_counter_timer (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        rx_load_a,
  input  wire        rx_load_b,
  input  wire        x1_tick,
  input  wire        ct_ext_clk_pin,
  output reg         ct_out,
  output wire        ct_pin_out,
  output wire        ct_pin_oe,
  output wire        ct_irq,
  output wire [3:0]  baud_from_ct,
  output wire [3:0]  force_16x,
  output wire        timeout_on_a,
  output wire        timeout_on_b
);

  reg  [7:0]              reload_low_byte;
  reg  [7:0]              reload_high_byte;
  reg  [7:0]              aux_control;
  reg  [7:0]              interrupt_mask;
  reg  [`UCT_CSEL_W-1:0]  clock_select;
  reg  [`UCT_CNT_W-1:0]   count;
  reg                     ready;
  reg                     running;
  reg                     to_en_a;
  reg                     to_en_b;
  reg                     load_pend;
  reg                     load_hold;
  reg                     wr_pend;
  reg  [`UCT_A_W-1:0]     wr_addr;

  wire                    ext_level;
  wire                    tick;
  wire                    access;
  wire                    rd_now;
  wire [`UCT_A_W-1:0]     addr;
  wire                    timeout_mode;
  wire                    timer_mode;
  wire [`UCT_CNT_W-1:0]   reload;
  wire                    cmd_start;
  wire                    cmd_stop;
  wire                    wr_cmd_a;
  wire                    wr_cmd_b;
  wire                    to_on_a;
  wire                    to_off_a;
  wire                    to_on_b;
  wire                    to_off_b;
  wire                    to_arm;
  wire                    rx_event;
  wire                    fall;
  wire                    set_ready;
  wire                    clr_ready;

  reg  [`UCT_CNT_W-1:0]   next_count;
  reg                     next_out;
  reg                     next_running;
  reg                     next_pend;
  reg                     next_hold;
  reg  [31:0]             next_rdata;

  uct_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in (ct_ext_clk_pin),
    .sync_out (ext_level)
  );

  uct_tick u_tick (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .src_sel   (aux_control[`UCT_AUX_SRC_HI:`UCT_AUX_SRC_LO]),
    .ext_level (ext_level),
    .x1_tick   (x1_tick),
    .tick      (tick)
  );

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `UCT_HRESP_OKAY;

  assign access = hsel & hready & htrans[`UCT_HTRANS_NSEQ_BIT];
  assign addr   = haddr[`UCT_A_W-1:0];
  assign rd_now = access & ~hwrite;

  assign reload       = {reload_high_byte, reload_low_byte};
  assign timeout_mode = to_en_a | to_en_b;
  assign timer_mode   = aux_control[`UCT_AUX_MODE_BIT] & ~timeout_mode;

  // Start and stop are reads of reserved addresses; data ignored
  assign cmd_start = rd_now & (addr == `UCT_A_START) & ~timeout_mode;
  assign cmd_stop  = rd_now & (addr == `UCT_A_STOP) & ~timeout_mode;

  assign wr_cmd_a = wr_pend & (wr_addr == `UCT_A_CMD_A);
  assign wr_cmd_b = wr_pend & (wr_addr == `UCT_A_CMD_B);
  assign to_on_a  = wr_cmd_a & (hwdata[7:4] == `UCT_CMD_TO_ON);
  assign to_off_a = wr_cmd_a & (hwdata[7:4] == `UCT_CMD_TO_OFF);
  assign to_on_b  = wr_cmd_b & (hwdata[7:4] == `UCT_CMD_TO_ON);
  assign to_off_b = wr_cmd_b & (hwdata[7:4] == `UCT_CMD_TO_OFF);
  assign to_arm   = to_on_a | to_on_b;

  // Only channels in timeout mode feed the restart; OR of both
  assign rx_event = timeout_mode &
                    ((rx_load_a & to_en_a) | (rx_load_b & to_en_b));

  // Counter mode fall comes from the count hitting zero
  assign fall = ct_out & ~next_out;

  assign set_ready = fall;
  assign clr_ready = cmd_stop | to_arm | rx_event;

  always @* begin
    next_count   = count;
    next_out     = ct_out;
    next_running = running;
    next_pend    = load_pend;
    next_hold    = load_hold;
    if (to_arm) begin
      // Held stopped until the next character arrives
      next_running = 1'b0;
      next_pend    = 1'b0;
      next_hold    = 1'b0;
    end else if (timeout_mode) begin
      if (rx_event) begin
        next_pend = 1'b1;
        next_out  = 1'b1;
      end
      if (tick) begin
        if (load_hold) begin
          // Second tick after the load: reload and go
          next_count   = reload;
          next_running = 1'b1;
          next_hold    = 1'b0;
        end else if (load_pend) begin
          // First tick after the load: stop
          next_running = 1'b0;
          next_pend    = rx_event;
          next_hold    = 1'b1;
        end else if (running & ~rx_event) begin
          if (count == `UCT_CNT_ZERO) begin
            next_count = `UCT_CNT_ROLL;
          end else begin
            next_count = count - `UCT_CNT_ONE;
            if (count == `UCT_CNT_ONE) begin
              next_out = 1'b0;
            end
          end
        end
      end
    end else if (timer_mode) begin
      next_pend = 1'b0;
      next_hold = 1'b0;
      if (cmd_start) begin
        next_count = reload;
      end else if (tick) begin
        // Free running; stop does not halt the square wave
        if (count <= `UCT_CNT_ONE) begin
          next_count = reload;
          next_out   = ~ct_out;
        end else begin
          next_count = count - `UCT_CNT_ONE;
        end
      end
    end else begin
      next_pend = 1'b0;
      next_hold = 1'b0;
      if (cmd_start) begin
        next_count   = reload;
        next_running = 1'b1;
        next_out     = 1'b1;
      end else if (cmd_stop) begin
        next_running = 1'b0;
      end else if (tick & running) begin
        if (count == `UCT_CNT_ZERO) begin
          next_count = `UCT_CNT_ROLL;
        end else begin
          next_count = count - `UCT_CNT_ONE;
          if (count == `UCT_CNT_ONE) begin
            next_out = 1'b0;
          end
        end
      end
    end
  end

  always @* begin
    next_rdata = `UCT_ZERO32;
    case (addr)
      `UCT_A_RELOAD_LO:  next_rdata[7:0] = reload_low_byte;
      `UCT_A_RELOAD_HI:  next_rdata[7:0] = reload_high_byte;
      // Live count; in timer mode software must not trust it
      `UCT_A_COUNT_LO:   next_rdata[7:0] = count[7:0];
      `UCT_A_COUNT_HI:   next_rdata[7:0] = count[15:8];
      `UCT_A_AUX_CTRL:   next_rdata[7:0] = aux_control;
      `UCT_A_INT_STATUS: next_rdata[`UCT_ISR_READY_BIT] = ready;
      `UCT_A_INT_MASK:   next_rdata[7:0] = interrupt_mask;
      `UCT_A_CMD_A:      next_rdata[0] = to_en_a;
      `UCT_A_CMD_B:      next_rdata[0] = to_en_b;
      `UCT_A_CLK_SEL:    next_rdata[`UCT_CSEL_W-1:0] = clock_select;
      default:           next_rdata = `UCT_ZERO32;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata           <= `UCT_ZERO32;
      wr_pend          <= 1'b0;
      wr_addr          <= {`UCT_A_W{1'b0}};
      reload_low_byte  <= 8'h00;
      reload_high_byte <= 8'h00;
      aux_control      <= 8'h00;
      interrupt_mask   <= 8'h00;
      clock_select     <= {`UCT_CSEL_W{1'b0}};
      to_en_a          <= 1'b0;
      to_en_b          <= 1'b0;
      count            <= `UCT_CNT_ZERO;
      ct_out           <= 1'b1;
      running          <= 1'b0;
      load_pend        <= 1'b0;
      load_hold        <= 1'b0;
      ready            <= 1'b0;
    end else if (ce) begin
      wr_pend <= access & hwrite;
      wr_addr <= addr;
      if (rd_now) begin
        hrdata <= next_rdata;
      end
      if (wr_pend) begin
        case (wr_addr)
          `UCT_A_RELOAD_LO: reload_low_byte  <= hwdata[7:0];
          `UCT_A_RELOAD_HI: reload_high_byte <= hwdata[7:0];
          `UCT_A_AUX_CTRL:  aux_control      <= hwdata[7:0] & `UCT_AUX_MASK;
          `UCT_A_INT_MASK:  interrupt_mask   <= hwdata[7:0];
          `UCT_A_CLK_SEL:   clock_select     <= hwdata[`UCT_CSEL_W-1:0];
          default:          ;
        endcase
      end
      if (to_on_a) begin
        to_en_a <= 1'b1;
      end else if (to_off_a) begin
        to_en_a <= 1'b0;
      end
      if (to_on_b) begin
        to_en_b <= 1'b1;
      end else if (to_off_b) begin
        to_en_b <= 1'b0;
      end
      count     <= next_count;
      ct_out    <= next_out;
      running   <= next_running;
      load_pend <= next_pend;
      load_hold <= next_hold;
      // An expiry in the clearing cycle still wins
      if (set_ready) begin
        ready <= 1'b1;
      end else if (clr_ready) begin
        ready <= 1'b0;
      end
    end
  end

  assign ct_irq = ready & interrupt_mask[`UCT_ISR_READY_BIT];

  // Counter output may also drive a general I/O pin
  assign ct_pin_out = ct_out;
  assign ct_pin_oe  = aux_control[`UCT_AUX_PIN_BIT];

  // Any channel taking the counter as baud source runs 16x
  assign baud_from_ct = clock_select;
  assign force_16x    = clock_select;

  assign timeout_on_a = to_en_a;
  assign timeout_on_b = to_en_b;

endmodule

// File: verification/uct_rx_model.sv
`timescale 1ns/100ps
module uct_rx_model #(
  parameter TDIV = 4
) (
  input  logic hclk,
  input  logic hresetn,
  output logic x1_tick,
  output logic rx_load_a,
  output logic rx_load_b
);
  logic [3:0] div;
  // Even tick spacing keeps timer half periods exact
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div     <= 4'h0;
      x1_tick <= 1'b0;
    end else begin
      div     <= (div == TDIV - 1) ? 4'h0 : div + 4'h1;
      x1_tick <= (div == TDIV - 1);
    end
  end
  initial begin
    rx_load_a = 1'b0;
    rx_load_b = 1'b0;
  end
  // One character moved into a receive FIFO
  task load(input logic ch);
    @(posedge hclk);
    if (ch) rx_load_b <= 1'b1;
    else rx_load_a <= 1'b1;
    @(posedge hclk);
    rx_load_a <= 1'b0;
    rx_load_b <= 1'b0;
    // Outputs launched by the load edge settle before the caller looks
    @(negedge hclk);
  endtask
endmodule

// File: verification/uct_counter_timer_sva.sv
`timescale 1ns/100ps
`include "uct_map.vh"
module uct_counter_timer_sva (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic        rx_load_a,
  input logic        rx_load_b,
  input logic        ct_out,
  input logic        ct_pin_out,
  input logic        ct_irq,
  input logic [3:0]  baud_from_ct,
  input logic [3:0]  force_16x,
  input logic        timeout_on_a,
  input logic        timeout_on_b
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic cmd_a_dp;
  assign take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_a_dp <= 1'b0;
    else cmd_a_dp <= take && hwrite && haddr[7:0] == `UCT_A_CMD_A;
  end
  okay_resp_a: assert property (hresp == 1'b0 && hreadyout)
    else $error("bus answer not ready or not okay");
  pin_follow_a: assert property (ct_pin_out == ct_out)
    else $error("counter pin differs from output");
  force_sixteen_a: assert property (force_16x == baud_from_ct)
    else $error("counter baud source without 16x");
  load_restart_a: assert property (((timeout_on_a && rx_load_a) || (timeout_on_b && rx_load_b))
    && !ct_out |=> ct_out && !ct_irq)
    else $error("late character did not restart");
  stop_clears_a: assert property (take && !hwrite && haddr[7:0] == `UCT_A_STOP && !timeout_on_a
    && !timeout_on_b |=> !ct_irq || $fell(ct_out))
    else $error("stop left ready interrupt");
  timeout_hold_a: assert property (take && !hwrite && haddr[7:0] == `UCT_A_STOP && timeout_on_a
    && ct_irq && !rx_load_a && !rx_load_b |=> ct_irq)
    else $error("stop acted in timeout mode");
  cmd_on_a: assert property (cmd_a_dp && hwdata[7:4] == `UCT_CMD_TO_ON |=> timeout_on_a)
    else $error("timeout enable not taken");
  cmd_off_a: assert property (cmd_a_dp && hwdata[7:4] == `UCT_CMD_TO_OFF |=> !timeout_on_a)
    else $error("timeout disable not taken");
endmodule
bind uct_counter_timer uct_counter_timer_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .rx_load_a, .rx_load_b, .ct_out, .ct_pin_out,
  .ct_irq, .baud_from_ct, .force_16x, .timeout_on_a, .timeout_on_b);

// File: verification/test_uart_block_counter_timer.sv
`timescale 1ns/100ps
`include "uct_map.vh"
module test_uart_block_counter_timer;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, x1_tick, rx_load_a, rx_load_b;
  logic        ct_out, ct_pin_out, ct_pin_oe, ct_irq, timeout_on_a, timeout_on_b;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [3:0]  baud_from_ct, force_16x;
  logic [2:0]  hsize;
  logic        ce, ct_ext_clk_pin;
  int          err_total, checked, n;
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0;
    haddr = 0; hwdata = 0; htrans = 0;
    ce = 1; hsize = 3'b010; ct_ext_clk_pin = 0;
  end
  always #12.5 hclk = ~hclk;
  uct_rx_model u_rx (.hclk(hclk), .hresetn(hresetn), .x1_tick(x1_tick),
    .rx_load_a(rx_load_a), .rx_load_b(rx_load_b));
  uct_counter_timer u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_load_a(rx_load_a), .rx_load_b(rx_load_b), .x1_tick(x1_tick),
    .ct_ext_clk_pin(ct_ext_clk_pin),
    .ct_out(ct_out), .ct_pin_out(ct_pin_out), .ct_pin_oe(ct_pin_oe), .ct_irq(ct_irq),
    .baud_from_ct(baud_from_ct), .force_16x(force_16x), .timeout_on_a(timeout_on_a),
    .timeout_on_b(timeout_on_b));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    hsize <= 3'b010;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'b00; hsel <= 0; hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
    // Let register outputs written at this edge settle before any check
    @(negedge hclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk(q, e);
  endtask
  // Settled sampling on the falling edge; bounded so a stuck output cannot hang
  task wait_sig(input logic irq, input logic v);
    n = 0;
    while ((irq ? ct_irq : ct_out) !== v && n < 3000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask
  // One rising edge on the external counter clock pin
  task pin_pulse;
    @(posedge hclk);
    ct_ext_clk_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    ct_ext_clk_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    err_total++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    chk(ct_out, 1);
    rd_chk(`UCT_A_INT_STATUS, 0);
    xfer(1, `UCT_A_RELOAD_LO, 32'h03);
    xfer(1, `UCT_A_RELOAD_HI, 32'h01);
    rd_chk(`UCT_A_RELOAD_HI, 32'h01);
    rd_chk(8'h3c, 0);
    xfer(1, `UCT_A_AUX_CTRL, 32'h78);
    rd_chk(`UCT_A_AUX_CTRL, 32'h78);
    chk(ct_pin_oe, 1);
    xfer(1, `UCT_A_CLK_SEL, 32'h05);
    chk(force_16x, 4'h5);
    chk(baud_from_ct, 4'h5);
    $display("register test done");
    xfer(1, `UCT_A_AUX_CTRL, 32'h20);
    xfer(0, `UCT_A_START, 0);
    rd_chk(`UCT_A_COUNT_HI, 32'h01);
    wait_sig(0, 0);
    rd_chk(`UCT_A_INT_STATUS, 32'h08);
    rd_chk(`UCT_A_COUNT_HI, 32'hff);
    xfer(1, `UCT_A_INT_MASK, 32'h08);
    chk(ct_irq, 1);
    xfer(0, `UCT_A_STOP, 0);
    rd_chk(`UCT_A_INT_STATUS, 0);
    $display("counter test done");
    xfer(1, `UCT_A_RELOAD_LO, 32'h03);
    xfer(1, `UCT_A_RELOAD_HI, 32'h00);
    xfer(1, `UCT_A_AUX_CTRL, 32'h60);
    // Timer counts down from the old count until start reloads it
    xfer(0, `UCT_A_START, 0);
    wait_sig(0, 1);
    wait_sig(0, 0);
    chk(n, 12);
    wait_sig(0, 1);
    chk(n, 12);
    // Clock enable low must freeze the square wave past its half period
    @(posedge hclk);
    ce <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(ct_out, 1);
    ce <= 1'b1;
    wait_sig(0, 0);
    xfer(0, `UCT_A_STOP, 0);
    rd_chk(`UCT_A_INT_STATUS, 0);
    wait_sig(0, 1);
    wait_sig(0, 0);
    rd_chk(`UCT_A_INT_STATUS, 32'h08);
    $display("timer test done");
    xfer(1, `UCT_A_AUX_CTRL, 32'h00);
    xfer(1, `UCT_A_RELOAD_LO, 32'h02);
    xfer(0, `UCT_A_START, 0);
    pin_pulse;
    rd_chk(`UCT_A_COUNT_LO, 32'h01);
    pin_pulse;
    chk(ct_out, 0);
    $display("pin clock test done");
    xfer(1, `UCT_A_RELOAD_LO, 32'h04);
    xfer(1, `UCT_A_AUX_CTRL, 32'h20);
    xfer(1, `UCT_A_CMD_A, 32'ha0);
    chk(timeout_on_a, 1);
    rd_chk(`UCT_A_INT_STATUS, 0);
    repeat (100) @(posedge hclk);
    chk(ct_irq, 0);
    u_rx.load(0);
    wait_sig(1, 1);
    chk(n >= 16 && n <= 36, 1);
    xfer(0, `UCT_A_STOP, 0);
    rd_chk(`UCT_A_INT_STATUS, 32'h08);
    u_rx.load(1);
    chk(ct_irq, 1);
    u_rx.load(0);
    chk(ct_irq, 0);
    rd_chk(`UCT_A_INT_STATUS, 0);
    xfer(1, `UCT_A_CMD_B, 32'ha0);
    u_rx.load(1);
    repeat (16) @(posedge hclk);
    u_rx.load(0);
    repeat (16) @(posedge hclk);
    chk(ct_irq, 0);
    wait_sig(1, 1);
    rd_chk(`UCT_A_INT_STATUS, 32'h08);
    xfer(1, `UCT_A_CMD_A, 32'hc0);
    xfer(1, `UCT_A_CMD_B, 32'hc0);
    chk({timeout_on_a, timeout_on_b}, 0);
    $display("timeout test done");
    finish_test;
  end
endmodule
